/* File: rtl/ccpv_edge.sv */
// Capture edge detector with rising-edge prescaler
`timescale 1ns/100ps
`default_nettype none

module ccpv_edge
  import ccpv_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic [3:0] mode,
  input  wire logic       level,
  output logic            hit
);

  logic       prev;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  wire        rise = level & ~prev;
  wire        fall = ~level & prev;

  always_comb begin
    hit      = 1'b0;
    next_cnt = cnt;
    unique case (mode)
      CCPV_M_CAP_ANY:  hit = rise | fall;
      CCPV_M_CAP_FALL: hit = fall;
      CCPV_M_CAP_RISE: hit = rise;
      CCPV_M_CAP_R4,
      CCPV_M_CAP_R16: begin
        if (rise) begin
          if (cnt == ((mode == CCPV_M_CAP_R4) ? CCPV_PRESC_4 : CCPV_PRESC_16)) begin
            hit      = 1'b1;
            next_cnt = 4'h0;
          end else begin
            next_cnt = cnt + 4'h1;
          end
        end
      end
      default: begin
        hit      = 1'b0;
        next_cnt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prev <= 1'b0;
      cnt  <= 4'h0;
    end else if (ce) begin
      prev <= level;
      cnt  <= clr ? 4'h0 : next_cnt;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/ccpv_pkg.sv */
// Constants for the capture/compare/PWM value and timer-select block
package ccpv_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned CCPV_DATA_W  = 32;
  localparam int unsigned CCPV_ADDR_W  = 8;
  localparam int unsigned CCPV_REG_W   = 8;
  localparam int unsigned CCPV_VAL_W   = 16;
  localparam int unsigned CCPV_PW_W    = 10;
  localparam int unsigned CCPV_NT_W    = 8;
  localparam int unsigned CCPV_FINE_W  = 2;
  localparam int unsigned CCPV_SRC_N   = 8;
  localparam int unsigned CCPV_CTS_W   = 3;
  localparam int unsigned CCPV_TSEL_W  = 2;
  localparam int unsigned CCPV_CH_N    = 5;
  localparam int unsigned CCPV_PWM_N   = 2;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] CCPV_OFF_VAL_LO = 8'h00;
  localparam logic [7:0] CCPV_OFF_VAL_HI = 8'h04;
  localparam logic [7:0] CCPV_OFF_CTRL   = 8'h08;
  localparam logic [7:0] CCPV_OFF_CAPSRC = 8'h0C;
  localparam logic [7:0] CCPV_OFF_TSEL_A = 8'h10;
  localparam logic [7:0] CCPV_OFF_TSEL_B = 8'h14;

  // ****************************************
  // Control register layout and reset values
  // ****************************************
  localparam int unsigned CCPV_EN_BIT    = 7;
  localparam int unsigned CCPV_OUT_BIT   = 5;
  localparam int unsigned CCPV_FMT_BIT   = 4;
  localparam int unsigned CCPV_MODE_MSB  = 3;
  localparam int unsigned CCPV_TSELB_MSB = 5;
  localparam logic [3:0] CCPV_MODE_RST   = 4'h0;
  localparam logic [2:0] CCPV_CTS_RST    = 3'h0;
  localparam logic [7:0] CCPV_TSEL_A_RST = 8'h55;
  localparam logic [5:0] CCPV_TSEL_B_RST = 6'h15;

  // ****************************************
  // Timer-select codes
  // ****************************************
  localparam logic [1:0] CCPV_TSEL_FIRST  = 2'h1;
  localparam logic [1:0] CCPV_TSEL_SECOND = 2'h2;
  localparam logic [1:0] CCPV_TSEL_THIRD  = 2'h3;

  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [3:0] CCPV_M_OFF       = 4'h0;
  localparam logic [3:0] CCPV_M_TOGG_CLR  = 4'h1;
  localparam logic [3:0] CCPV_M_TOGG      = 4'h2;
  localparam logic [3:0] CCPV_M_CAP_ANY   = 4'h3;
  localparam logic [3:0] CCPV_M_CAP_FALL  = 4'h4;
  localparam logic [3:0] CCPV_M_CAP_RISE  = 4'h5;
  localparam logic [3:0] CCPV_M_CAP_R4    = 4'h6;
  localparam logic [3:0] CCPV_M_CAP_R16   = 4'h7;
  localparam logic [3:0] CCPV_M_SET       = 4'h8;
  localparam logic [3:0] CCPV_M_CLR       = 4'h9;
  localparam logic [3:0] CCPV_M_PULSE     = 4'hA;
  localparam logic [3:0] CCPV_M_PULSE_CLR = 4'hB;
  localparam logic [3:0] CCPV_M_PWM       = 4'hF;

  // Last prescaler count before a capture fires
  localparam logic [3:0] CCPV_PRESC_4  = 4'h3;
  localparam logic [3:0] CCPV_PRESC_16 = 4'hF;

endpackage

/* File: rtl/ccpv_top.sv */
// Capture/compare/PWM channel: value registers, timer selection, APB slave
//
// Contract
// - Capture loads low and high value bytes from selected wide timer.
// - Compare matches high:low value pair against selected wide timer count.
// - Right-aligned PWM width is high bits 1..0 above low byte.
// - Left-aligned PWM width is high byte above low bits 7..6.
// - Channel timer fields pick first, second or third timer pair; 00 reserved.
// - Standalone PWM timer fields pick narrow timer; 00 reserved.
// - Unimplemented register bits read as zero.
// - Value bytes have no reset value.
// - Alignment bit: 1 left, 0 right, used only in PWM.
// - New pulse width is buffered only at narrow timer period match.
// - Mode field selects off, capture, compare or PWM function.
// - Every mode event flags interrupt and may trigger a conversion.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module ccpv_top
  import ccpv_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] wide_timer_first,
  input  wire logic [15:0] wide_timer_second,
  input  wire logic [15:0] wide_timer_third,
  input  wire logic [7:0]  narrow_timer_first,
  input  wire logic [7:0]  narrow_timer_second,
  input  wire logic [7:0]  narrow_timer_third,
  input  wire logic [1:0]  narrow_fine_first,
  input  wire logic [1:0]  narrow_fine_second,
  input  wire logic [1:0]  narrow_fine_third,
  input  wire logic        narrow_period_first,
  input  wire logic        narrow_period_second,
  input  wire logic        narrow_period_third,
  input  wire logic [7:0]  capture_pins,
  input  wire logic        conv_source_this,
  output logic             ccp_out,
  output logic             wide_timer_clear,
  output logic             channel_interrupt_flag,
  output logic             conv_trigger,
  output logic      [9:0]  channel_timer_sel,
  output logic      [3:0]  pwm_timer_sel
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] value_low_byte;
  logic [7:0] value_high_byte;
  logic       ctrl_en;
  logic       alignment_bit;
  logic [3:0] ctrl_mode;
  logic [2:0] capture_source_reg;
  logic [7:0] timer_select_reg_a;
  logic [5:0] timer_select_reg_b;

  // ****************************************
  // Channel state
  // ****************************************
  logic       out_q;
  logic       next_out;
  logic       eq_q;
  logic       pulse_q;
  logic [9:0] pw_buf;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic       cap_hit;

  // ****************************************
  // APB decode
  // ****************************************
  wire setup  = psel & ~penable;
  wire access = psel & penable;

  wire hit_lo  = (paddr == CCPV_OFF_VAL_LO);
  wire hit_hi  = (paddr == CCPV_OFF_VAL_HI);
  wire hit_ctl = (paddr == CCPV_OFF_CTRL);
  wire hit_cap = (paddr == CCPV_OFF_CAPSRC);
  wire hit_ta  = (paddr == CCPV_OFF_TSEL_A);
  wire hit_tb  = (paddr == CCPV_OFF_TSEL_B);
  wire hit_any = hit_lo | hit_hi | hit_ctl | hit_cap | hit_ta | hit_tb;

  wire wr     = access & pwrite;
  wire wr_lo  = wr & hit_lo;
  wire wr_hi  = wr & hit_hi;
  wire wr_ctl = wr & hit_ctl;
  wire wr_cap = wr & hit_cap;
  wire wr_ta  = wr & hit_ta;
  wire wr_tb  = wr & hit_tb;

  // Zero wait states: read data is registered in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  wire [7:0] ctrl_rd = {ctrl_en, 1'b0, out_q, alignment_bit, ctrl_mode};
  wire [7:0] cap_rd  = {5'h00, capture_source_reg};
  wire [7:0] tb_rd   = {2'h0, timer_select_reg_b};

  wire [7:0] rd_byte = hit_lo  ? value_low_byte  :
                       hit_hi  ? value_high_byte :
                       hit_ctl ? ctrl_rd         :
                       hit_cap ? cap_rd          :
                       hit_ta  ? timer_select_reg_a :
                       hit_tb  ? tb_rd           : 8'h00;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************
  // Timer selection
  // ****************************************
  wire [1:0] channel1_timer_field = timer_select_reg_a[1:0];

  wire sel_third  = (channel1_timer_field == CCPV_TSEL_THIRD);
  wire sel_second = (channel1_timer_field == CCPV_TSEL_SECOND);

  // Reserved code 00 falls to the first pair; software must not use it
  wire [15:0] sel_wide = sel_third  ? wide_timer_third  :
                         sel_second ? wide_timer_second : wide_timer_first;
  wire [7:0] sel_narrow = sel_third  ? narrow_timer_third  :
                          sel_second ? narrow_timer_second : narrow_timer_first;
  wire [1:0] sel_fine = sel_third  ? narrow_fine_third  :
                        sel_second ? narrow_fine_second : narrow_fine_first;
  wire sel_period = sel_third  ? narrow_period_third  :
                    sel_second ? narrow_period_second : narrow_period_first;

  assign channel_timer_sel = {timer_select_reg_b[1:0], timer_select_reg_a};
  assign pwm_timer_sel = timer_select_reg_b[CCPV_TSELB_MSB:2];

  // ****************************************
  // Mode decode
  // ****************************************
  // Mode field decode
  wire mode_off = (ctrl_mode == CCPV_M_OFF);
  wire mode_on  = ctrl_en & ~mode_off;
  wire is_pwm   = (ctrl_mode == CCPV_M_PWM);
  wire is_cap   = (ctrl_mode >= CCPV_M_CAP_ANY) && (ctrl_mode <= CCPV_M_CAP_R16);
  wire is_cmp   = (ctrl_mode == CCPV_M_TOGG_CLR) || (ctrl_mode == CCPV_M_TOGG)
                  || ((ctrl_mode >= CCPV_M_SET) && (ctrl_mode <= CCPV_M_PULSE_CLR));
  wire is_pulse = (ctrl_mode == CCPV_M_PULSE) || (ctrl_mode == CCPV_M_PULSE_CLR);
  wire clr_tmr  = (ctrl_mode == CCPV_M_TOGG_CLR) || (ctrl_mode == CCPV_M_PULSE_CLR);

  // ****************************************
  // Capture input
  // ****************************************
  // Pins come from outside the clock domain
  genvar gi;
  generate
    for (gi = 0; gi < CCPV_SRC_N; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else if (ce) begin
          sync1[gi] <= capture_pins[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  wire cap_level = sync2[capture_source_reg];

  ccpv_edge u_edge (
    .mclk  (mclk),
    .nrst  (nrst),
    .ce    (ce),
    .clr   (~mode_on | ~is_cap),
    .mode  (ctrl_mode),
    .level (cap_level),
    .hit   (cap_hit)
  );

  wire cap_load = mode_on & is_cap & cap_hit;

  // ****************************************
  // Compare
  // ****************************************
  // Value pair against timer
  wire cmp_eq = ({value_high_byte, value_low_byte} == sel_wide);

  // Only the first cycle of a match counts, a stalled timer fires once
  wire cmp_hit = mode_on & is_cmp & cmp_eq & ~eq_q;

  // ****************************************
  // PWM
  // ****************************************
  // Right and left alignment, picked by the alignment bit
  wire [9:0] pw_right = {value_high_byte[1:0], value_low_byte};
  wire [9:0] pw_left = {value_high_byte, value_low_byte[7:6]};
  wire [9:0] pw_raw = alignment_bit ? pw_left : pw_right;

  wire       pwm_act    = mode_on & is_pwm;
  wire [9:0] time_base  = {sel_narrow, sel_fine};
  wire       pwm_period = pwm_act & sel_period;
  // Width above the period never matches, so the pin stays high
  wire       pwm_match  = pwm_act & (time_base == pw_buf);

  // ****************************************
  // Output pin
  // ****************************************
  always_comb begin
    next_out = out_q;
    if (!mode_on) begin
      next_out = 1'b0;
    end else if (pwm_period) begin
      next_out = (pw_raw != 10'h000);
    end else if (pwm_match) begin
      next_out = 1'b0;
    end else if (cmp_hit) begin
      unique case (ctrl_mode)
        CCPV_M_SET:       next_out = 1'b1;
        CCPV_M_CLR:       next_out = 1'b0;
        CCPV_M_PULSE,
        CCPV_M_PULSE_CLR: next_out = 1'b1;
        default:          next_out = ~out_q;
      endcase
    end else if (pulse_q) begin
      next_out = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      out_q   <= 1'b0;
      eq_q    <= 1'b0;
      pulse_q <= 1'b0;
    end else if (ce) begin
      out_q   <= next_out;
      eq_q    <= cmp_eq & mode_on & is_cmp;
      pulse_q <= cmp_hit & is_pulse;
    end
  end

  assign ccp_out = out_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pw_buf <= 10'h000;
    end else if (ce) begin
      if (!mode_on) begin
        pw_buf <= 10'h000;
      end else if (pwm_period) begin
        pw_buf <= pw_raw;
      end
    end
  end

  // ****************************************
  // Events
  // ****************************************
  // Every mode event flags
  wire evt = cap_load | cmp_hit | pwm_period;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      channel_interrupt_flag <= 1'b0;
      conv_trigger           <= 1'b0;
      wide_timer_clear       <= 1'b0;
    end else if (ce) begin
      channel_interrupt_flag <= evt;
      conv_trigger     <= evt & conv_source_this;
      wide_timer_clear <= cmp_hit & clr_tmr;
    end
  end

  // ****************************************
  // Value registers
  // ****************************************
  // No reset branch
  // Capture wins over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (cap_load) begin
        value_low_byte <= sel_wide[7:0];
      end else if (wr_lo) begin
        value_low_byte <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (cap_load) begin
        value_high_byte <= sel_wide[15:8];
      end else if (wr_hi) begin
        value_high_byte <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // Control and select registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_en       <= 1'b0;
      alignment_bit <= 1'b0;
      ctrl_mode     <= CCPV_MODE_RST;
    end else if (ce && wr_ctl) begin
      ctrl_en       <= pwdata[CCPV_EN_BIT];
      alignment_bit <= pwdata[CCPV_FMT_BIT];
      ctrl_mode     <= pwdata[CCPV_MODE_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      capture_source_reg <= CCPV_CTS_RST;
    end else if (ce && wr_cap) begin
      capture_source_reg <= pwdata[CCPV_CTS_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timer_select_reg_a <= CCPV_TSEL_A_RST;
    end else if (ce && wr_ta) begin
      timer_select_reg_a <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timer_select_reg_b <= CCPV_TSEL_B_RST;
    end else if (ce && wr_tb) begin
      timer_select_reg_b <= pwdata[CCPV_TSELB_MSB:0];
    end
  end

endmodule

`default_nettype wire

/* File: verification/ccp_value_and_timer_select_bench.sv */
// Self-checking bench for the value and timer-select block
`timescale 1ns/100ps
`default_nettype none

module ccp_value_and_timer_select_bench
  import ccpv_pkg::*;
;
  localparam logic [7:0] PERIOD  = 8'h0F;
  localparam int         PER_CYC = 4 * (PERIOD + 1);

  logic        mclk    = 1'h0;
  logic        nrst    = 1'h0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [31:0] pwdata  = 32'h0;
  logic        run     = 1'h0;
  logic [7:0]  cap     = 8'h00;
  logic        conv    = 1'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, ccp_out, wide_timer_clear;
  logic        channel_interrupt_flag, conv_trigger, hit;
  logic [15:0] wt1, wt2, wt3, exp_v;
  logic [7:0]  nt;
  logic [1:0]  fine;
  logic [9:0]  channel_timer_sel;
  logic [3:0]  pwm_timer_sel;
  int          errors = 0, cmp_count = 0, flag_cnt = 0, cyc = 0, hi_cnt, trig_cnt = 0;
  logic [7:0]  cap_ctl [6] = '{8'h05, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};
  int          cap_exp [6] = '{0, 32, 16, 16, 4, 1};
  logic [7:0]  cmp_ctl [6] = '{8'h88, 8'h89, 8'h81, 8'h82, 8'h8A, 8'h8B};
  logic        cmp_out [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};

  ccpv_top DUT (
    .mclk, .nrst, .ce(1'h1), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .wide_timer_first(wt1), .wide_timer_second(wt2),
    .wide_timer_third(wt3), .narrow_timer_first(nt), .narrow_timer_second(nt),
    .narrow_timer_third(nt), .narrow_fine_first(fine), .narrow_fine_second(fine),
    .narrow_fine_third(fine), .narrow_period_first(hit), .narrow_period_second(hit),
    .narrow_period_third(hit), .capture_pins(cap), .conv_source_this(conv), .ccp_out,
    .wide_timer_clear, .channel_interrupt_flag, .conv_trigger, .channel_timer_sel,
    .pwm_timer_sel
  );

  ccpv_far_model #(.PERIOD(PERIOD)) u_far (
    .mclk, .nrst, .run, .clr(wide_timer_clear), .wt1, .wt2, .wt3, .nt, .fine, .hit
  );

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // ********
  // Tasks
  // ********
  task automatic test_done();
    $display("Compares %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      errors++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    rd = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic pulse();
    repeat (4) @(posedge mclk);
    cap[0] <= 1'h1;
    repeat (4) @(posedge mclk);
    cap[0] <= 1'h0;
  endtask

  task automatic meas();
    hi_cnt = 0;
    repeat (PER_CYC) begin
      @(negedge mclk);
      if (ccp_out === 1'h1) hi_cnt++;
    end
  endtask

  // Hang guard; the full sequence needs well under a tenth of this
  always @(posedge mclk) begin
    cyc++;
    if (channel_interrupt_flag === 1'h1) flag_cnt++;
    if (conv_trigger === 1'h1) trig_cnt++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  // ********
  // Sequence
  // ********
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'h1;
    rdc(CCPV_OFF_TSEL_A, 32'h55);
    rdc(CCPV_OFF_TSEL_B, 32'h15);
    wr(CCPV_OFF_TSEL_B, 32'hFF);
    rdc(CCPV_OFF_TSEL_B, 32'h3F);
    wr(CCPV_OFF_CAPSRC, 32'hFFFFFFFF);
    rdc(CCPV_OFF_CAPSRC, 32'h07);
    wr(8'h18, 32'hFF);
    rdc(8'h18, 32'h00);
    wr(CCPV_OFF_CAPSRC, 32'h00);
    wr(CCPV_OFF_TSEL_B, 32'h2D);
    rdc(CCPV_OFF_TSEL_B, 32'h2D);
    chk({26'h0, pwm_timer_sel, channel_timer_sel[9:8]}, 32'h2D);
    for (int c = 1; c < 4; c++) begin
      wr(CCPV_OFF_TSEL_A, {24'h0, 6'h15, c[1:0]});
      wr(CCPV_OFF_CTRL, 32'h85);
      pulse();
      exp_v = (c == 1) ? 16'h1234 : (c == 2) ? 16'h5670 : 16'h9ABC;
      rdc(CCPV_OFF_VAL_LO, {24'h0, exp_v[7:0]});
      rdc(CCPV_OFF_VAL_HI, {24'h0, exp_v[15:8]});
      chk({30'h0, channel_timer_sel[1:0]}, {30'h0, c[1:0]});
    end
    foreach (cap_ctl[i]) begin
      wr(CCPV_OFF_CTRL, 32'h00);
      wr(CCPV_OFF_CTRL, {24'h0, cap_ctl[i]});
      flag_cnt = 0;
      trig_cnt = 0;
      conv     <= i[0];
      repeat (16) pulse();
      repeat (8) @(posedge mclk);
      chk_n(flag_cnt, cap_exp[i]);
      chk_n(trig_cnt, i[0] ? cap_exp[i] : 0);
    end
    wr(CCPV_OFF_TSEL_A, 32'h55);
    wr(CCPV_OFF_VAL_LO, 32'h3C);
    wr(CCPV_OFF_VAL_HI, 32'h12);
    foreach (cmp_ctl[i]) begin
      wr(CCPV_OFF_CTRL, {24'h0, cmp_ctl[i]});
      flag_cnt = 0;
      run <= 1'h1;
      repeat (30) @(posedge mclk);
      run <= 1'h0;
      chk_n(flag_cnt, 1);
      chk({31'h0, ccp_out}, {31'h0, cmp_out[i]});
      rdc(CCPV_OFF_CTRL, {24'h0, cmp_ctl[i] | {2'h0, cmp_out[i], 5'h00}});
    end
    wr(CCPV_OFF_CTRL, 32'h00);
    wr(CCPV_OFF_VAL_LO, 32'h20);
    wr(CCPV_OFF_VAL_HI, 32'hFC);
    wr(CCPV_OFF_CTRL, 32'h8F);
    @(negedge mclk iff hit === 1'h1);
    meas();
    chk_n(hi_cnt, 10'h020 + 1);
    // New width written mid-period must wait for the next period match
    fork
      meas();
      begin
        wr(CCPV_OFF_VAL_HI, 32'h04);
        wr(CCPV_OFF_VAL_LO, 32'hBF);
        wr(CCPV_OFF_CTRL, 32'h9F);
      end
    join
    chk_n(hi_cnt, 10'h020 + 1);
    meas();
    chk_n(hi_cnt, 10'h012 + 1);
    test_done();
  end
endmodule
`default_nettype wire

/* File: verification/ccpv_far_model.sv */
// Timer-side model: three wide timers and one narrow 10-bit time base
`timescale 1ns/100ps
`default_nettype none

module ccpv_far_model
  import ccpv_pkg::*;
#(
  parameter logic [7:0] PERIOD = 8'h0F
)
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        run,
  input  wire logic        clr,
  output logic      [15:0] wt1,
  output logic      [15:0] wt2,
  output logic      [15:0] wt3,
  output logic      [7:0]  nt,
  output logic      [1:0]  fine,
  output logic             hit
);
  // Halted timers sit at fixed values so captures are predictable
  always_ff @(posedge mclk) begin
    if (!nrst || !run) begin
      wt1 <= 16'h1234;
    end else if (clr) begin
      wt1 <= 16'h0000;
    end else begin
      wt1 <= wt1 + 16'h0001;
    end
  end
  assign wt2 = wt1 ^ 16'h4444;
  assign wt3 = wt1 ^ 16'h8888;

  assign hit = {nt, fine} == {PERIOD, 2'h3};
  always_ff @(posedge mclk) begin
    if (!nrst || hit) begin
      {nt, fine} <= 10'h000;
    end else begin
      {nt, fine} <= {nt, fine} + 10'h001;
    end
  end
endmodule
`default_nettype wire

/* File: verification/ccpv_top_assertions.sv */
// Port-level concurrent checks for the value and timer-select block
`timescale 1ns/100ps
`default_nettype none

module ccpv_top_chk
  import ccpv_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        narrow_period_first,
  input wire logic        conv_source_this,
  input wire logic        ccp_out,
  input wire logic        wide_timer_clear,
  input wire logic        channel_interrupt_flag,
  input wire logic        conv_trigger,
  input wire logic [9:0]  channel_timer_sel,
  input wire logic [3:0]  pwm_timer_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic wr_en;
  logic mapped;
  logic pwm_on;
  assign wr_en  = psel && penable && pwrite && ce;
  assign mapped = paddr inside {CCPV_OFF_VAL_LO, CCPV_OFF_VAL_HI, CCPV_OFF_CTRL,
                                CCPV_OFF_CAPSRC, CCPV_OFF_TSEL_A, CCPV_OFF_TSEL_B};

  // Shadow of the mode, since PWM checks must not fire in compare modes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pwm_on <= 1'h0;
    end else if (wr_en && paddr == CCPV_OFF_CTRL) begin
      pwm_on <= pwdata[CCPV_EN_BIT] && pwdata[3:0] == CCPV_M_PWM;
    end
  end

  // ********
  // Checks
  // ********
  property p_tsel_a;
    wr_en && paddr == CCPV_OFF_TSEL_A |=> channel_timer_sel[7:0] == $past(pwdata[7:0]);
  endproperty
  a_tsel_a: assert property (p_tsel_a) else $error("channel select wrong");

  property p_tsel_b;
    wr_en && paddr == CCPV_OFF_TSEL_B
      |=> {pwm_timer_sel, channel_timer_sel[9:8]} == $past(pwdata[5:0]);
  endproperty
  a_tsel_b: assert property (p_tsel_b) else $error("pwm select wrong");

  property p_rd_zero;
    prdata[31:8] == 24'h000000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("upper read bits set");

  property p_unmapped;
    psel && !penable && !pwrite && !mapped |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");

  property p_conv;
    conv_trigger || channel_interrupt_flag
      |-> conv_trigger == (channel_interrupt_flag && $past(conv_source_this));
  endproperty
  a_conv: assert property (p_conv) else $error("conversion trigger wrong");

  property p_clear;
    wide_timer_clear |-> ccp_out != $past(ccp_out);
  endproperty
  a_clear: assert property (p_clear) else $error("timer clear without match");

  property p_off;
    wr_en && paddr == CCPV_OFF_CTRL && pwdata[3:0] == CCPV_M_OFF
      |-> ##2 (!ccp_out && !channel_interrupt_flag) [*3];
  endproperty
  a_off: assert property (p_off) else $error("channel active when off");

  property p_pwm_rise;
    pwm_on && $rose(ccp_out) |-> $past(narrow_period_first);
  endproperty
  a_pwm_rise: assert property (p_pwm_rise) else $error("pwm edge off period");
endmodule

bind ccpv_top ccpv_top_chk u_chk (.*);
`default_nettype wire
